// >>> hdl/clock_synth_config_registers.sv
/*
 * Configuration register bank of a fractional-N clock synthesizer.
 * Byte registers are written and read on the control port clock; the
 * applied copy, pin drivers and ratio scaling run on sys_clk.
 * Assumes a control port decoder in the ctrlClk domain that presents
 * address, data and a one-cycle write strobe, with writes spaced at
 * least four ctrlClk cycles apart, and analog pins that are asynchronous.
 */
`timescale 1ns/1ps
`include "clock_synth_regs.svh"

// Notes on behaviour
// - lock status reads 0 locked, 1 unlocked
// - aux driver off bit floats aux pin
// - synth pin driver off bit floats pin
// - shift select scales ratio left or right
// - aux source: reference, synth copy, lock
// - lock source uses lock pin style bit
// - style 0 push-pull high; 1 open drain
// - operation needs both port enables set
// - port enables accepted in any order
// - freeze holds 02h-03h writes unapplied
// - unfrozen writes apply immediately
// - four bytes form ratio, MSB first
// - function config: style bit6, divider bits4-3
// - divider select: 4, 2, 1, reserved
module clock_synth_config_registers (
    input wire logic sys_clk,                        // system clock, 25 MHz
    input wire logic reset_n,                        // sync reset, low
    input wire logic ctrlClk,                        // control port clock
    input wire logic [7:0] ctrlAddr,                 // register address
    input wire clock_synth_pkg::byte_t ctrlWrData,   // write byte
    input wire logic ctrlWrEn,                       // write strobe
    output logic [7:0] ctrlRdData,                   // read byte
    input wire logic pllLocked,                      // loop lock, async
    input wire logic internalReferenceClock,         // divided reference
    input wire logic synthClk,                       // synthesized clock
    output logic synthPinOut,                        // synth pin level
    output logic synthPinOe,                         // synth pin enable
    output logic auxPinOut,                          // aux pin level
    output logic auxPinOe,                           // aux pin enable
    output clock_synth_pkg::eff_ratio_t effectiveRatio, // scaled ratio
    output logic [2:0] refDivisor,                   // reference divisor
    output logic controlPortMode                     // both enables set
);
    import clock_synth_pkg::*;

    // ==========================================================
    // control port domain: reset and lock synchronisers
    logic linkRstMeta_reg;
    logic linkRstN_reg;
    logic lockLinkMeta_reg;
    logic lockLink_reg;

    // no reset here: linkRstMeta_reg and linkRstN_reg produce the reset itself
    always_ff @(posedge ctrlClk) begin
        linkRstMeta_reg <= reset_n;
        linkRstN_reg <= linkRstMeta_reg;
        lockLinkMeta_reg <= pllLocked;
        lockLink_reg <= lockLinkMeta_reg;
    end

    // ==========================================================
    // control port domain: stored registers
    byte_t devCtrl_reg, devCtrl_next;
    byte_t devCfg1_reg, devCfg1_next;
    byte_t globalCfg_reg, globalCfg_next;
    byte_t funcCfg1_reg, funcCfg1_next;
    logic [3:0][7:0] ratio_reg, ratio_next;
    logic updTgl_reg, updTgl_next;
    byte_t rdData_reg, rdData_next;
    logic unlockLink;

    assign unlockLink = ~lockLink_reg;

    always_comb begin
        devCtrl_next = devCtrl_reg;
        devCfg1_next = devCfg1_reg;
        globalCfg_next = globalCfg_reg;
        funcCfg1_next = funcCfg1_reg;
        ratio_next = ratio_reg;
        updTgl_next = updTgl_reg;
        if (ctrlWrEn) begin
            updTgl_next = ~updTgl_reg;
            case (ctrlAddr)
                // unlock bit has no storage, so writes to it vanish
                `OFS_DEVICE_CONTROL: begin
                    devCtrl_next = ctrlWrData & `MASK_DEVICE_CONTROL;
                end
                // each enable lives in its own register, any order
                `OFS_DEVICE_CONFIGURATION_ONE: begin
                    devCfg1_next = ctrlWrData
                        & `MASK_DEVICE_CONFIGURATION_ONE;
                end
                `OFS_GLOBAL_CONFIGURATION: begin
                    globalCfg_next = ctrlWrData
                        & `MASK_GLOBAL_CONFIGURATION;
                end
                `OFS_USER_RATIO_B3: ratio_next[3] = ctrlWrData;
                `OFS_USER_RATIO_B2: ratio_next[2] = ctrlWrData;
                `OFS_USER_RATIO_B1: ratio_next[1] = ctrlWrData;
                `OFS_USER_RATIO_B0: ratio_next[0] = ctrlWrData;
                `OFS_FUNCTION_CONFIGURATION_ONE: begin
                    funcCfg1_next = ctrlWrData
                        & `MASK_FUNCTION_CONFIGURATION_ONE;
                end
                default: begin
                    // unmapped: nothing to hand over
                    updTgl_next = updTgl_reg;
                end
            endcase
        end
        case (ctrlAddr)
            `OFS_DEVICE_CONTROL: begin
                rdData_next = devCtrl_reg;
                rdData_next[`BIT_UNLOCK] = unlockLink;
            end
            `OFS_DEVICE_CONFIGURATION_ONE: rdData_next = devCfg1_reg;
            `OFS_GLOBAL_CONFIGURATION: rdData_next = globalCfg_reg;
            `OFS_USER_RATIO_B3: rdData_next = ratio_reg[3];
            `OFS_USER_RATIO_B2: rdData_next = ratio_reg[2];
            `OFS_USER_RATIO_B1: rdData_next = ratio_reg[1];
            `OFS_USER_RATIO_B0: rdData_next = ratio_reg[0];
            `OFS_FUNCTION_CONFIGURATION_ONE: rdData_next = funcCfg1_reg;
            default: rdData_next = `RST_BYTE;
        endcase
    end

    always_ff @(posedge ctrlClk) begin
        if (!linkRstN_reg) begin
            devCtrl_reg <= `RST_BYTE;
            devCfg1_reg <= `RST_BYTE;
            globalCfg_reg <= `RST_BYTE;
            funcCfg1_reg <= `RST_BYTE;
            ratio_reg <= `RST_RATIO;
            updTgl_reg <= 1'b0;
            rdData_reg <= `RST_BYTE;
        end else begin
            devCtrl_reg <= devCtrl_next;
            devCfg1_reg <= devCfg1_next;
            globalCfg_reg <= globalCfg_next;
            funcCfg1_reg <= funcCfg1_next;
            ratio_reg <= ratio_next;
            updTgl_reg <= updTgl_next;
            rdData_reg <= rdData_next;
        end
    end

    assign ctrlRdData = rdData_reg;

    // ==========================================================
    // system domain: synchronisers
    // clock-like pins are sampled, so only low rates pass faithfully
    logic updMeta_reg, updSync_reg, updSeen_reg;
    logic lockMeta_reg, lockSync_reg;
    logic refMeta_reg, refSync_reg;
    logic synMeta_reg, synSync_reg;
    logic updPulse;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            updMeta_reg <= 1'b0;
            updSync_reg <= 1'b0;
            updSeen_reg <= 1'b0;
            lockMeta_reg <= 1'b0;
            lockSync_reg <= 1'b0;
            refMeta_reg <= 1'b0;
            refSync_reg <= 1'b0;
            synMeta_reg <= 1'b0;
            synSync_reg <= 1'b0;
        end else begin
            updMeta_reg <= updTgl_reg;
            updSync_reg <= updMeta_reg;
            updSeen_reg <= updSync_reg;
            lockMeta_reg <= pllLocked;
            lockSync_reg <= lockMeta_reg;
            refMeta_reg <= internalReferenceClock;
            refSync_reg <= refMeta_reg;
            synMeta_reg <= synthClk;
            synSync_reg <= synMeta_reg;
        end
    end

    assign updPulse = updSync_reg ^ updSeen_reg;

    // ==========================================================
    // system domain: applied configuration
    // stored bytes are stable here because writes are spaced apart
    byte_t apCtrl_reg, apCtrl_next;
    byte_t apCfg1_reg, apCfg1_next;
    byte_t apGlobal_reg, apGlobal_next;
    byte_t apFunc_reg, apFunc_next;
    logic [31:0] apRatio_reg, apRatio_next;

    always_comb begin
        apCtrl_next = apCtrl_reg;
        apCfg1_next = apCfg1_reg;
        apGlobal_next = apGlobal_reg;
        apFunc_next = apFunc_reg;
        apRatio_next = apRatio_reg;
        if (updPulse) begin
            apGlobal_next = globalCfg_reg;
            apFunc_next = funcCfg1_reg;
            apRatio_next = ratio_reg;
            // clearing freeze releases everything held back
            if (!globalCfg_reg[`BIT_FREEZE]) begin
                apCtrl_next = devCtrl_reg;
                apCfg1_next = devCfg1_reg;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            apCtrl_reg <= `RST_BYTE;
            apCfg1_reg <= `RST_BYTE;
            apGlobal_reg <= `RST_BYTE;
            apFunc_reg <= `RST_BYTE;
            apRatio_reg <= `RST_RATIO;
        end else begin
            apCtrl_reg <= apCtrl_next;
            apCfg1_reg <= apCfg1_next;
            apGlobal_reg <= apGlobal_next;
            apFunc_reg <= apFunc_next;
            apRatio_reg <= apRatio_next;
        end
    end

    // ==========================================================
    // system domain: pins, ratio scaling, divider
    logic modeNow, unlockSys, auxOff, synOff, lockStyle;
    logic [2:0] shiftSel;
    aux_source_e auxSrc;
    ref_div_e refSel;
    logic synOut_reg, synOut_next, synOe_reg, synOe_next;
    logic auxOut_reg, auxOut_next, auxOe_reg, auxOe_next;
    logic mode_reg;
    eff_ratio_t effRatio_reg, effRatio_next;
    logic [2:0] refDiv_reg, refDiv_next;

    assign modeNow = apCfg1_reg[`BIT_PORT_ENABLE_A]
        & apGlobal_reg[`BIT_PORT_ENABLE_B];
    assign unlockSys = ~lockSync_reg;
    assign auxOff = apCtrl_reg[`BIT_AUX_DRIVER_OFF];
    assign synOff = apCtrl_reg[`BIT_SYNTH_PIN_DRIVER_OFF];
    assign lockStyle = apFunc_reg[`BIT_LOCK_PIN_STYLE];
    assign shiftSel = apCfg1_reg[`MSB_RATIO_SHIFT_SELECT:
        `LSB_RATIO_SHIFT_SELECT];
    assign auxSrc = aux_source_e'(apCfg1_reg[`MSB_AUX_SOURCE_SELECT:
        `LSB_AUX_SOURCE_SELECT]);
    assign refSel = ref_div_e'(apFunc_reg[`MSB_REF_DIVIDER_SELECT:
        `LSB_REF_DIVIDER_SELECT]);

    always_comb begin
        synOut_next = synSync_reg;
        synOe_next = modeNow & ~synOff;
        auxOe_next = modeNow & ~auxOff;
        case (auxSrc)
            AUX_SRC_REFERENCE: auxOut_next = refSync_reg;
            AUX_SRC_SYNTH_COPY: auxOut_next = synSync_reg;
            AUX_SRC_LOCK: begin
                if (lockStyle) begin
                    // open drain: pull low only while unlocked
                    auxOut_next = 1'b0;
                    auxOe_next = modeNow & ~auxOff & unlockSys;
                end else begin
                    auxOut_next = unlockSys;
                end
            end
            default: auxOut_next = 1'b0;
        endcase
        // low codes shift left by 0-3 with no bit lost, high codes shift right by 1-4 and drop low bits
        if (shiftSel[2]) begin
            effRatio_next = {3'h0, apRatio_reg} >> ({1'b0, shiftSel[1:0]}
                + 3'h1);
        end else begin
            effRatio_next = {3'h0, apRatio_reg} << shiftSel[1:0];
        end
        case (refSel)
            REF_DIV_TWO: refDiv_next = `REF_DIVIDE_BY_2;
            REF_DIV_ONE: refDiv_next = `REF_DIVIDE_BY_1;
            // reserved code falls back to the slowest-safe divider
            default: refDiv_next = `REF_DIVIDE_BY_4;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            synOut_reg <= 1'b0;
            synOe_reg <= 1'b0;
            auxOut_reg <= 1'b0;
            auxOe_reg <= 1'b0;
            mode_reg <= 1'b0;
            effRatio_reg <= '0;
            refDiv_reg <= `REF_DIVIDE_BY_4;
        end else begin
            synOut_reg <= synOut_next;
            synOe_reg <= synOe_next;
            auxOut_reg <= auxOut_next;
            auxOe_reg <= auxOe_next;
            mode_reg <= modeNow;
            effRatio_reg <= effRatio_next;
            refDiv_reg <= refDiv_next;
        end
    end

    assign synthPinOut = synOut_reg;
    assign synthPinOe = synOe_reg;
    assign auxPinOut = auxOut_reg;
    assign auxPinOe = auxOe_reg;
    assign controlPortMode = mode_reg;
    assign effectiveRatio = effRatio_reg;
    assign refDivisor = refDiv_reg;

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence s_frozenUpdate;
        updPulse && globalCfg_reg[`BIT_FREEZE];
    endsequence
    sequence s_openUpdate;
        updPulse && !globalCfg_reg[`BIT_FREEZE];
    endsequence

    a_lock_status_read: assert property (
        @(posedge ctrlClk) disable iff (!linkRstN_reg)
        ctrlAddr == `OFS_DEVICE_CONTROL |=>
        ctrlRdData[`BIT_UNLOCK] == !$past(lockLink_reg))
        else $error("lock status bit wrong");
    a_aux_off_float: assert property (
        auxOff |=> !auxPinOe)
        else $error("aux pin driven while off");
    a_synth_off_float: assert property (
        (synOff || !modeNow) |=> !synthPinOe)
        else $error("synth pin driven while off");
    a_synth_drive_on: assert property (
        (modeNow && !synOff) |=> synthPinOe)
        else $error("synth pin not driven");
    a_ratio_shift_left: assert property (
        !shiftSel[2] |=> effectiveRatio ==
        ({3'h0, $past(apRatio_reg)} << $past(shiftSel[1:0])))
        else $error("left ratio shift wrong");
    a_ratio_shift_right: assert property (
        shiftSel[2] |=> effectiveRatio ==
        ({3'h0, $past(apRatio_reg)} >> ($past(shiftSel[1:0]) + 3'h1)))
        else $error("right ratio shift wrong");
    a_aux_synth_copy: assert property (
        auxSrc == AUX_SRC_SYNTH_COPY |=> auxPinOut == $past(synSync_reg))
        else $error("aux copy of synth clock wrong");
    a_lock_push_pull: assert property (
        (auxSrc == AUX_SRC_LOCK && !lockStyle && modeNow && !auxOff)
        |=> auxPinOe && auxPinOut == !$past(lockSync_reg))
        else $error("push-pull lock indicator wrong");
    a_lock_open_drain: assert property (
        (auxSrc == AUX_SRC_LOCK && lockStyle) |=> !auxPinOut
        && (!auxPinOe || !$past(lockSync_reg)))
        else $error("open-drain lock indicator wrong");
    a_mode_gates_pins: assert property (
        !controlPortMode |-> !synthPinOe && !auxPinOe)
        else $error("pins driven outside control port mode");
    a_freeze_holds_cfg: assert property (
        s_frozenUpdate |=> $stable(apCtrl_reg) && $stable(apCfg1_reg))
        else $error("frozen write took effect");
    a_update_applies: assert property (
        s_openUpdate |=> apCtrl_reg == $past(devCtrl_reg)
        && apCfg1_reg == $past(devCfg1_reg))
        else $error("unfrozen write not applied");
    a_ratio_low_byte: assert property (
        @(posedge ctrlClk) disable iff (!linkRstN_reg)
        ctrlWrEn && ctrlAddr == `OFS_USER_RATIO_B0 |=>
        ratio_reg[0] == $past(ctrlWrData))
        else $error("ratio low byte not stored");
    a_ref_divider_map: assert property (
        refSel == REF_DIV_ONE |=> refDivisor == `REF_DIVIDE_BY_1)
        else $error("reference divider wrong");
endmodule

// >>> common/clock_synth_regs.svh
/*
 * Register offsets, field positions, masks and reset values of the
 * synthesizer configuration bank.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef CLOCK_SYNTH_REGS_SVH
`define CLOCK_SYNTH_REGS_SVH

// ==========================================================
// register offsets
`define OFS_DEVICE_CONTROL 8'h02
`define OFS_DEVICE_CONFIGURATION_ONE 8'h03
`define OFS_GLOBAL_CONFIGURATION 8'h05
`define OFS_USER_RATIO_B3 8'h06
`define OFS_USER_RATIO_B2 8'h07
`define OFS_USER_RATIO_B1 8'h08
`define OFS_USER_RATIO_B0 8'h09
`define OFS_FUNCTION_CONFIGURATION_ONE 8'h16

// ==========================================================
// writable bits per register, reserved bits read zero
`define MASK_DEVICE_CONTROL 8'h03
`define MASK_DEVICE_CONFIGURATION_ONE 8'hE7
`define MASK_GLOBAL_CONFIGURATION 8'h09
`define MASK_FUNCTION_CONFIGURATION_ONE 8'h58

// ==========================================================
// reset values
`define RST_BYTE 8'h00
`define RST_RATIO 32'h0000_0000

// ==========================================================
// field positions
`define BIT_UNLOCK 7
`define BIT_AUX_DRIVER_OFF 1
`define BIT_SYNTH_PIN_DRIVER_OFF 0
`define MSB_RATIO_SHIFT_SELECT 7
`define LSB_RATIO_SHIFT_SELECT 5
`define MSB_AUX_SOURCE_SELECT 2
`define LSB_AUX_SOURCE_SELECT 1
`define BIT_PORT_ENABLE_A 0
`define BIT_FREEZE 3
`define BIT_PORT_ENABLE_B 0
`define BIT_LOCK_PIN_STYLE 6
`define MSB_REF_DIVIDER_SELECT 4
`define LSB_REF_DIVIDER_SELECT 3

// ==========================================================
// reference divider values
`define REF_DIVIDE_BY_4 3'h4
`define REF_DIVIDE_BY_2 3'h2
`define REF_DIVIDE_BY_1 3'h1

`endif

// >>> common/clock_synth_pkg.sv
/*
 * Types shared by the synthesizer configuration bank and its bench.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package clock_synth_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [34:0] eff_ratio_t;
    // codes follow declaration order: 00 ref, 01 reserved, 10 synth, 11 lock
    typedef enum logic [1:0] {
        AUX_SRC_REFERENCE,
        AUX_SRC_RESERVED,
        AUX_SRC_SYNTH_COPY,
        AUX_SRC_LOCK
    } aux_source_e;
    typedef enum logic [1:0] {
        REF_DIV_FOUR,
        REF_DIV_TWO,
        REF_DIV_ONE,
        REF_DIV_RESERVED
    } ref_div_e;
endpackage

// >>> sim/ctrl_host_model.sv
/*
 * Host model on the control port: makes the link clock in frames and
 * drives address, write byte and strobe; reads the registered byte.
 * Assumes the bench calls its tasks hierarchically, one at a time.
 */
`timescale 1ns/1ps
module ctrl_host_model (
    output logic ctrlClk,             // link clock, stands between frames
    output logic [7:0] ctrlAddr,      // register address
    output logic [7:0] ctrlWrData,    // write byte
    output logic ctrlWrEn,            // write strobe
    input wire logic [7:0] ctrlRdData // read byte
);
    // ==========================================================
    // frame clock
    initial begin
        ctrlClk = 1'b1;
        ctrlAddr = 8'hFF;
        ctrlWrData = 8'h00;
        ctrlWrEn = 1'b0;
    end

    // 30 ns period; returns 2 ns after a rising edge
    task automatic cyc(input int n);
        repeat (n) begin
            #13 ctrlClk = 1'b0;
            #15 ctrlClk = 1'b1;
            #2;
        end
    endtask

    // ==========================================================
    // accesses
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ctrlAddr = a;
        ctrlWrData = d;
        ctrlWrEn = 1'b1;
        cyc(1);
        ctrlWrEn = 1'b0;
        // released data shows the inverse so stale bytes cannot pass
        ctrlWrData = ~d;
        cyc(5);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        ctrlAddr = a;
        // extra edges cover the lock bit synchroniser
        cyc(4);
        d = ctrlRdData;
        ctrlAddr = ~a;
        cyc(1);
    endtask

    // no atomic update: bytes apply as they arrive, msb first
    task automatic wr_ratio(input logic [31:0] r);
        wr(8'h06, r[31:24]);
        wr(8'h07, r[23:16]);
        wr(8'h08, r[15:8]);
        wr(8'h09, r[7:0]);
    endtask
endmodule

// >>> sim/clock_synth_config_registers_tb_top.sv
/*
 * Self-checking bench of the synthesizer configuration bank.
 * Assumes the host model drives the control port on its own clock.
 */
`timescale 1ns/1ps
module clock_synth_config_registers_tb_top;
    import clock_synth_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic pllLocked = 1'b0;
    logic refIn = 1'b0;
    logic synthIn = 1'b0;
    logic ctrlClk, ctrlWrEn;
    logic [7:0] ctrlAddr, ctrlWrData, ctrlRdData;
    logic synthPinOut, synthPinOe, auxPinOut, auxPinOe, controlPortMode;
    eff_ratio_t effectiveRatio;
    logic [2:0] refDivisor;
    int fail_count = 0;
    int n_checks = 0;
    int seed = 49;
    logic [7:0] rstAddr [9] = '{8'h02, 8'h03, 8'h05, 8'h06, 8'h07,
        8'h08, 8'h09, 8'h16, 8'h04};

    always #20 sys_clk = ~sys_clk;

    ctrl_host_model host (.ctrlClk(ctrlClk), .ctrlAddr(ctrlAddr),
        .ctrlWrData(ctrlWrData), .ctrlWrEn(ctrlWrEn),
        .ctrlRdData(ctrlRdData));

    clock_synth_config_registers uut (.sys_clk(sys_clk), .reset_n(reset_n),
        .ctrlClk(ctrlClk), .ctrlAddr(ctrlAddr), .ctrlWrData(ctrlWrData),
        .ctrlWrEn(ctrlWrEn), .ctrlRdData(ctrlRdData), .pllLocked(pllLocked),
        .internalReferenceClock(refIn), .synthClk(synthIn),
        .synthPinOut(synthPinOut), .synthPinOe(synthPinOe),
        .auxPinOut(auxPinOut), .auxPinOe(auxPinOe),
        .effectiveRatio(effectiveRatio), .refDivisor(refDivisor),
        .controlPortMode(controlPortMode));

    // ==========================================================
    // helpers
    function automatic eff_ratio_t exp_ratio(input logic [31:0] r,
            input logic [2:0] c);
        eff_ratio_t e;
        e = {3'b000, r};
        if (c[2]) begin
            e = e >> (c[1:0] + 3'd1);
        end else begin
            e = e << c[1:0];
        end
        return e;
    endfunction

    task automatic chk_out(input string nm, input logic [34:0] e,
            input logic [34:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] g;
        host.rd(a, g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] reg %h expected %h seen %h", a, e, g);
        end
    endtask

    // applied effect lands a few sys_clk edges after the write
    task automatic settle;
        repeat (8) @(posedge sys_clk);
        #2;
    endtask

    task automatic w(input logic [7:0] a, input logic [7:0] d);
        host.wr(a, d);
        settle;
    endtask

    task automatic drive(input logic l, input logic rc, input logic sc);
        @(posedge sys_clk);
        #2;
        pllLocked = l;
        refIn = rc;
        synthIn = sc;
        settle;
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #3_000_000;
        fail_count++;
        tally_and_finish;
    end

    // ==========================================================
    // tests
    initial begin
        logic [31:0] r;
        logic [7:0] b;
        fork
            host.cyc(15);
            repeat (12) @(posedge sys_clk);
        join
        #2 reset_n = 1'b1;
        host.cyc(5);
        settle;
        chk_out("refDivisor", 3'h4, refDivisor);
        chk_out("controlPortMode", 1'b0, controlPortMode);
        host.wr(8'h04, 8'hFF);
        foreach (rstAddr[i]) chk_reg(rstAddr[i], (i == 0) ? 8'h80 : 8'h00);
        $display("test reset done");
        for (int o = 0; o < 2; o++) begin
            w(o ? 8'h03 : 8'h05, 8'h01);
            chk_out("controlPortMode", 1'b0, controlPortMode);
            w(o ? 8'h05 : 8'h03, 8'h01);
            chk_out("controlPortMode", 1'b1, controlPortMode);
            if (o == 0) begin
                w(8'h03, 8'h00);
                w(8'h05, 8'h00);
            end
        end
        $display("test enables done");
        // reserved bits and the lock bit are written high on purpose
        for (int v = 0; v < 4; v++) begin
            w(8'h02, 8'hFC | v[7:0]);
            chk_reg(8'h02, 8'h80 | v[7:0]);
            chk_out("synthPinOe", !v[0], synthPinOe);
            chk_out("auxPinOe", !v[1], auxPinOe);
        end
        w(8'h02, 8'h00);
        drive(1'b1, 1'b0, 1'b0);
        chk_reg(8'h02, 8'h00);
        $display("test driver off done");
        for (int i = 0; i < 8; i++) begin
            b = (i < 2) ? 8'h01 : (i < 4) ? 8'h05 : 8'h07;
            w(8'h16, (i >= 6) ? 8'h40 : 8'h00);
            w(8'h03, b);
            drive(i[0], i[0], i[0]);
            chk_out("synthPinOut", i[0], synthPinOut);
            chk_out("auxPinOut", (i < 4) ? i[0] : (i < 6) ? !i[0] : 1'b0,
                auxPinOut);
            chk_out("auxPinOe", (i == 7) ? 1'b0 : 1'b1, auxPinOe);
        end
        $display("test aux source done");
        for (int k = 0; k < 2; k++) begin
            r = k ? 32'hFFFF_FFFF : $random(seed);
            host.wr_ratio(r);
            chk_reg(8'h06, r[31:24]);
            chk_reg(8'h09, r[7:0]);
            for (int c = 0; c < 8; c++) begin
                w(8'h03, {c[2:0], 5'b00001});
                chk_out("effectiveRatio", exp_ratio(r, c[2:0]),
                    effectiveRatio);
            end
        end
        $display("test ratio done");
        for (int c = 0; c < 4; c++) begin
            // host keeps reserved bits of this register at default
            b = $random(seed) & 8'h58;
            b[4:3] = c[1:0];
            w(8'h16, b);
            chk_out("refDivisor", (c == 1) ? 3'h2 : (c == 2) ? 3'h1 : 3'h4,
                refDivisor);
            chk_reg(8'h16, b & 8'h58);
        end
        $display("test divider done");
        w(8'h05, 8'h09);
        w(8'h02, 8'h01);
        chk_out("synthPinOe", 1'b1, synthPinOe);
        chk_reg(8'h02, 8'h01);
        w(8'h05, 8'h01);
        chk_out("synthPinOe", 1'b0, synthPinOe);
        $display("test freeze done");
        tally_and_finish;
    end
endmodule
